// [src/aux_pin_consts.vh]
/*
 constants for the auxiliary pin b and power option register bank.
 assumes inclusion by bare name from the design files.
*/
`ifndef AUX_PIN_CONSTS_VH
`define AUX_PIN_CONSTS_VH
`define ADDR_PIN_B_CFG     12'h0c8
`define ADDR_POWER_OPTS    12'h0cc
`define IDX_PIN_B_CFG      8'h32
`define IDX_POWER_OPTS     8'h33
`define RST_PIN_B_CFG      8'h00
`define RST_POWER_OPTS     8'h00
`define POWER_WMASK        8'hec
`define DRIVE_HI           7
`define DRIVE_LO           6
`define EARLY_HI           4
`define EARLY_LO           3
`define FUNC_HI            2
`define FUNC_LO            0
`define BIT_STANDBY        7
`define BIT_LP_OSC         6
`define BIT_KEEP_PLL       5
`define BIT_RETRIM         3
`define BIT_PULSE_INT      2
`define FN_TRISTATE        3'h0
`define FN_IN_HIGH         3'h1
`define FN_IN_LOW          3'h2
`define FN_OUT_LOW_PULSE   3'h3
`define FN_OUT_HIGH_PULSE  3'h4
`define FN_CONST_HIGH      3'h5
`define FN_CONST_LOW       3'h6
`define EARLY_NONE         2'h0
`define EARLY_100          2'h1
`define EARLY_200          2'h2
`define LEAD_US_1          100
`define LEAD_US_2          200
`define CLK_MHZ            20
`define LEAD_CYC_1         (`LEAD_US_1 * `CLK_MHZ)
`define LEAD_CYC_2         (`LEAD_US_2 * `CLK_MHZ)
`define INT_PULSE_CYC      3'h4
`endif

// [src/pin_sync.v]
/*
 two flip-flop synchroniser for a single level.
 assumes the input comes from outside the clk_i domain.
*/
`timescale 1ns/1ps
module pin_sync (
    input  wire clk_i,
    input  wire rstn_i,
    input  wire d_i,
    output wire q_o
);
    reg meta;
    reg stable;
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta   <= 1'b0;
            stable <= 1'b0;
        end else begin
            meta   <= d_i;
            stable <= meta;
        end
    end
    assign q_o = stable;
endmodule

// [src/lead_timer.v]
/*
 delay line that lets an output assert a fixed time before a scheduled event.
 assumes the sequencer raises emit_pre_i the longest lead before the emitter fires;
 this module delays that request by the difference to the longest lead.
*/
`timescale 1ns/1ps
module lead_timer #(
    parameter CW = 13
) (
    input  wire          clk_i,
    input  wire          rstn_i,
    input  wire          start_i,
    input  wire [CW-1:0] len_i,
    output wire          busy_o
);
    reg [CW-1:0] count;
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count <= {CW{1'b0}};
        end else if (start_i) begin
            count <= len_i;
        end else if (count != {CW{1'b0}}) begin
            count <= count - {{(CW-1){1'b0}}, 1'b1};
        end
    end
    assign busy_o = (count != {CW{1'b0}});
endmodule

// [src/aux_pin_and_power_config.v]
/*
 apb register bank for auxiliary pin b and the power options, with the pin
 function, drive level, early assertion and interrupt signalling logic.
 assumes one clock, apb master in the same domain, pin and emitter timing
 signals from the measurement sequencer; pad input passes a synchroniser.
*/
// The APB slave port is this design's own decision.
//
// Contract
// RULE_01 - bits 7:6 of the pin b register pick drive level 1x, 2x, 3x or 4x.
// RULE_02 - bits 4:3 pick no lead, a 100 us lead or a 200 us lead before the emitter pulse.
// RULE_03 - the lead is applied only when the pin function is 3 or 4.
// RULE_04 - bits 2:0 pick tristate, input high, input low, pulse low, pulse high, high or low.
// RULE_05 - the host keeps pin a out of pulse modes while pin b uses mode 3 or 4.
// RULE_06 - bit 7 of power options lets the device enter timed standby while waiting.
// RULE_07 - bit 6 runs the device from the low power oscillator in timed standby.
// RULE_08 - bit 5 keeps the pll running while idle.
// RULE_09 - bit 3 allows oscillator retrimming, otherwise retrimming is blocked.
// RULE_10 - bit 2 makes the interrupt pin pulse, otherwise it holds until cleared.
// RULE_11 - the host clears a level interrupt before reading results, never in pulse mode.
// RULE_12 - the host writes zero to power option bits 4 and 1:0.
`timescale 1ns/1ps
`include "aux_pin_consts.vh"
module aux_pin_and_power_config #(
    parameter LEAD_CYC_1 = `LEAD_CYC_1,
    parameter LEAD_CYC_2 = `LEAD_CYC_2
) (
    input  wire        clk_i,
    input  wire        rstn_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    input  wire        emit_pre_i,
    input  wire        emit_active_i,
    input  wire        wait_period_i,
    input  wire        idle_i,
    input  wire        retrim_req_i,
    input  wire        int_event_i,
    input  wire        int_clear_i,
    input  wire        pin_b_pad_i,
    output reg         pin_b_pad_o,
    output reg         pin_b_pad_oe_n_o,
    output reg  [1:0]  pin_b_drive_level_o,
    output reg         pin_b_input_o,
    output reg         standby_timed_o,
    output reg         lp_osc_sel_o,
    output reg         pll_run_o,
    output reg         retrim_en_o,
    output reg         int_pin_o
);

////////////////////////////////////////////////////////////////////////////////
// register file

    reg  [7:0] aux_pin_b_config;
    reg  [7:0] power_options;
    reg [31:0] rdata;
    wire       wr_en  = psel_i & penable_i & pwrite_i;
    wire       hit_b  = (paddr_i == `ADDR_PIN_B_CFG);
    wire       hit_p  = (paddr_i == `ADDR_POWER_OPTS);
    wire       mapped = hit_b | hit_p;

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aux_pin_b_config <= `RST_PIN_B_CFG;
            power_options    <= `RST_POWER_OPTS;
        end else if (wr_en) begin
            if (hit_b) begin
                aux_pin_b_config <= pwdata_i[7:0];
            end
            // reserved bits kept at zero whatever the host writes [RULE_12]
            if (hit_p) begin
                power_options <= pwdata_i[7:0] & `POWER_WMASK;
            end
        end
    end

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata <= 32'h00000000;
        end else if (psel_i & ~penable_i & ~pwrite_i) begin
            if (hit_b) begin
                rdata <= {24'h000000, aux_pin_b_config};
            end else if (hit_p) begin
                rdata <= {24'h000000, power_options};
            end else begin
                rdata <= 32'h00000000;
            end
        end
    end

    assign prdata_o  = rdata;
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;

////////////////////////////////////////////////////////////////////////////////
// field decode

    wire [1:0] drive_sel = aux_pin_b_config[`DRIVE_HI:`DRIVE_LO];
    wire [1:0] early_sel = aux_pin_b_config[`EARLY_HI:`EARLY_LO];
    wire [2:0] func_sel  = aux_pin_b_config[`FUNC_HI:`FUNC_LO];

    function is_pulse_mode;
        input [2:0] f;
        begin
            is_pulse_mode = (f == `FN_OUT_LOW_PULSE) | (f == `FN_OUT_HIGH_PULSE);
        end
    endfunction

    wire pulse_mode = is_pulse_mode(func_sel);

////////////////////////////////////////////////////////////////////////////////
// early assertion: emit_pre_i arrives the longest lead before the pulse

    wire        pad_sync;
    wire        lead_busy;
    reg         pre_d;
    reg  [12:0] lead_len;
    reg         lead_on;
    wire        pre_rise = emit_pre_i & ~pre_d;

    pin_sync u_pad_sync (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .d_i    (pin_b_pad_i),
        .q_o    (pad_sync)
    );

    // the lead window ends at the pulse; lead_len delays the start inside it
    always @* begin
        case (early_sel) // [RULE_02]
            `EARLY_100: lead_len = LEAD_CYC_2[12:0] - LEAD_CYC_1[12:0];
            `EARLY_200: lead_len = 13'h0001;
            default:    lead_len = 13'h0000;
        endcase
    end

    lead_timer #(
        .CW (13)
    ) u_lead (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .start_i(pre_rise & pulse_mode & (lead_len != 13'h0000)),
        .len_i  (lead_len),
        .busy_o (lead_busy)
    );

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pre_d   <= 1'b0;
            lead_on <= 1'b0;
        end else begin
            pre_d <= emit_pre_i;
            // an undefined lead code gives no lead, like code 0
            if (!pulse_mode || !emit_pre_i || lead_len == 13'h0000) begin
                lead_on <= 1'b0; // [RULE_03]
            end else if (lead_busy && lead_len == 13'h0001) begin
                lead_on <= 1'b1;
            end else if (!lead_busy && !pre_rise) begin
                lead_on <= 1'b1;
            end
        end
    end

    wire emit_level = emit_active_i | lead_on;

////////////////////////////////////////////////////////////////////////////////
// pin function

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_b_pad_o         <= 1'b0;
            pin_b_pad_oe_n_o    <= 1'b1;
            pin_b_drive_level_o <= 2'h0;
            pin_b_input_o       <= 1'b0;
        end else begin
            pin_b_drive_level_o <= drive_sel; // [RULE_01]
            case (func_sel) // [RULE_04]
                `FN_IN_HIGH: begin
                    pin_b_pad_o      <= 1'b0;
                    pin_b_pad_oe_n_o <= 1'b1;
                    pin_b_input_o    <= pad_sync;
                end
                `FN_IN_LOW: begin
                    pin_b_pad_o      <= 1'b0;
                    pin_b_pad_oe_n_o <= 1'b1;
                    pin_b_input_o    <= ~pad_sync;
                end
                `FN_OUT_LOW_PULSE: begin
                    pin_b_pad_o      <= ~emit_level;
                    pin_b_pad_oe_n_o <= 1'b0;
                    pin_b_input_o    <= 1'b0;
                end
                `FN_OUT_HIGH_PULSE: begin
                    pin_b_pad_o      <= emit_level;
                    pin_b_pad_oe_n_o <= 1'b0;
                    pin_b_input_o    <= 1'b0;
                end
                `FN_CONST_HIGH: begin
                    pin_b_pad_o      <= 1'b1;
                    pin_b_pad_oe_n_o <= 1'b0;
                    pin_b_input_o    <= 1'b0;
                end
                `FN_CONST_LOW: begin
                    pin_b_pad_o      <= 1'b0;
                    pin_b_pad_oe_n_o <= 1'b0;
                    pin_b_input_o    <= 1'b0;
                end
                default: begin
                    pin_b_pad_o      <= 1'b0;
                    pin_b_pad_oe_n_o <= 1'b1;
                    pin_b_input_o    <= 1'b0;
                end
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////////////
// power options and interrupt signalling

    reg       int_level;
    reg [2:0] int_cnt;
    wire      pulse_int = power_options[`BIT_PULSE_INT];

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            standby_timed_o <= 1'b0;
            lp_osc_sel_o    <= 1'b0;
            pll_run_o       <= 1'b0;
            retrim_en_o     <= 1'b0;
        end else begin
            standby_timed_o <= power_options[`BIT_STANDBY] & wait_period_i; // [RULE_06]
            lp_osc_sel_o    <= power_options[`BIT_LP_OSC] & power_options[`BIT_STANDBY]
                               & wait_period_i; // [RULE_07]
            pll_run_o       <= ~idle_i | power_options[`BIT_KEEP_PLL]; // [RULE_08]
            retrim_en_o     <= power_options[`BIT_RETRIM] & retrim_req_i; // [RULE_09]
        end
    end

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            int_level <= 1'b0;
            int_cnt   <= 3'h0;
            int_pin_o <= 1'b0;
        end else begin
            // a new event wins over a clear in the same cycle [RULE_10]
            if (pulse_int) begin
                int_level <= 1'b0;
            end else if (int_event_i) begin
                int_level <= 1'b1;
            end else if (int_clear_i) begin
                int_level <= 1'b0;
            end
            if (pulse_int && int_event_i) begin
                int_cnt <= `INT_PULSE_CYC;
            end else if (int_cnt != 3'h0) begin
                int_cnt <= int_cnt - 3'h1;
            end
            int_pin_o <= pulse_int ? (int_event_i | (int_cnt > 3'h1))
                                   : (int_event_i | (int_level & ~int_clear_i));
        end
    end
endmodule

// [dv/emit_seq_model.sv]
/*
 model of the measurement sequencer: on fire_i it raises the pre-emit level
 for PRE cycles, then the emitter pulse for ON cycles, pre staying high.
 assumes the same clock as the register bank.
*/
`timescale 1ns/1ps
module emit_seq_model #(
    parameter PRE = 20,
    parameter ON  = 5
) (
    input  wire  clk_i,
    input  wire  fire_i,
    output logic pre_o,
    output logic active_o
);
    int cnt = 0;
    always @(posedge clk_i) begin
        if (fire_i && cnt == 0)
            cnt <= PRE + ON;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
    assign pre_o    = cnt > 0;
    assign active_o = cnt > 0 && cnt <= ON;
endmodule

// [dv/aux_pin_sva.sv]
/*
 assertions on the pin b and power option bank ports.
 assumes one clock domain and an apb master keeping the bus rules.
*/
`timescale 1ns/1ps
module aux_pin_sva #(
    parameter LEAD_CYC_1 = 2000,
    parameter LEAD_CYC_2 = 4000
) (
    input wire        clk_i,
    input wire        rstn_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire        pready_o,
    input wire        pslverr_o,
    input wire        wait_period_i,
    input wire        idle_i,
    input wire        retrim_req_i,
    input wire        int_event_i,
    input wire        int_clear_i,
    input wire        pin_b_pad_o,
    input wire        pin_b_pad_oe_n_o,
    input wire [1:0]  pin_b_drive_level_o,
    input wire        standby_timed_o,
    input wire        lp_osc_sel_o,
    input wire        pll_run_o,
    input wire        retrim_en_o,
    input wire        int_pin_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    wire       wr = psel_i && penable_i && pwrite_i;
    reg  [2:0] fn;
    reg        pulse;
    // shadow of the pin function and interrupt mode fields
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fn <= 3'h0;
            pulse <= 1'b0;
        end else if (wr && paddr_i == 12'h0c8) begin
            fn <= pwdata_i[2:0];
        end else if (wr && paddr_i == 12'h0cc) begin
            pulse <= pwdata_i[2];
        end
    end
    bus_answer_a: assert property (psel_i && penable_i |-> pready_o
        && pslverr_o == (paddr_i != 12'h0c8 && paddr_i != 12'h0cc))
        else $error("bus answer wrong");
    drive_level_a: assert property (wr && paddr_i == 12'h0c8 |->
        ##2 pin_b_drive_level_o == $past(pwdata_i[7:6], 2)) else $error("drive level wrong");
    static_level_a: assert property (fn inside {3'h5, 3'h6} && $past(fn) == fn
        |-> !pin_b_pad_oe_n_o && pin_b_pad_o == (fn == 3'h5)) else $error("static pad wrong");
    pin_tristate_a: assert property (fn == 3'h0 && $past(fn) == 3'h0
        |-> pin_b_pad_oe_n_o) else $error("pad driven in tristate");
    standby_cause_a: assert property ($rose(standby_timed_o)
        |-> $past(wait_period_i)) else $error("standby without wait");
    lp_osc_gate_a: assert property (lp_osc_sel_o |-> standby_timed_o)
        else $error("low power oscillator outside standby");
    pll_awake_a: assert property ($past(rstn_i) && !$past(idle_i) |-> pll_run_o)
        else $error("pll stopped while busy");
    retrim_cause_a: assert property ($rose(retrim_en_o) |-> $past(retrim_req_i))
        else $error("retrim without request");
    int_raise_a: assert property (int_event_i |=> int_pin_o)
        else $error("interrupt not raised");
    int_hold_a: assert property (!pulse && int_pin_o && !int_clear_i |=> int_pin_o)
        else $error("level interrupt dropped");
    int_pulse_a: assert property ($rose(int_pin_o) && pulse
        |-> int_pin_o [*4] ##1 !int_pin_o) else $error("pulse width wrong");
    cover property (wr && paddr_i == 12'h0cc);
    cover property ($rose(int_pin_o) && pulse);
    cover property ($fell(pin_b_pad_oe_n_o));
endmodule
bind aux_pin_and_power_config aux_pin_sva #(
    .LEAD_CYC_1(LEAD_CYC_1),
    .LEAD_CYC_2(LEAD_CYC_2)
) i_aux_pin_sva (.*);

// [dv/aux_pin_and_power_config_tb.sv]
/*
 self-checking bench for the pin b and power option bank.
 assumes short lead parameters 10 and 20 and a sequencer model.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module aux_pin_and_power_config_tb;
    logic        clk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic        wait_period_i = 0, idle_i = 0, retrim_req_i = 0, fire = 0;
    logic        int_event_i = 0, int_clear_i = 0, pin_b_pad_i = 0;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, rd;
    logic        er;
    wire  [31:0] prdata_o;
    wire  [1:0]  pin_b_drive_level_o;
    wire         pready_o, pslverr_o, pin_b_pad_o, pin_b_pad_oe_n_o, pin_b_input_o;
    wire         standby_timed_o, lp_osc_sel_o, pll_run_o, retrim_en_o, int_pin_o;
    wire         emit_pre_i, emit_active_i;
    wire  [3:0]  pwr = {standby_timed_o, lp_osc_sel_o, pll_run_o, retrim_en_o};
    int          n_fail = 0, n_checks = 0, cyc = 0;
    aux_pin_and_power_config #(.LEAD_CYC_1(10), .LEAD_CYC_2(20)) i_aux_pin_and_power_config (.*);
    emit_seq_model #(.PRE(20), .ON(5)) i_emit_seq_model (.clk_i(clk_i), .fire_i(fire),
        .pre_o(emit_pre_i), .active_o(emit_active_i));
    initial forever #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) @(posedge clk_i);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic t_reset();
        `CHK(pin_b_pad_oe_n_o, 1'b1)
        apb(0, 12'h0c8, 0);
        `CHK(rd, 32'h0)
        apb(0, 12'h0cc, 0);
        `CHK(rd, 32'h0)
        apb(0, 12'h0d0, 0);
        `CHK({er, rd}, 33'h1_0000_0000)
        $display("test reset done");
    endtask
    task automatic t_pin();
        for (int d = 0; d < 4; d++) begin
            apb(1, 12'h0c8, {24'h0, d[1:0], 6'h05});
            repeat (3) @(posedge clk_i);
            `CHK(pin_b_drive_level_o, d[1:0])
            `CHK({pin_b_pad_oe_n_o, pin_b_pad_o}, 2'b01)
        end
        apb(1, 12'h0c8, 32'h06);
        repeat (3) @(posedge clk_i);
        `CHK({pin_b_pad_oe_n_o, pin_b_pad_o}, 2'b00)
        apb(0, 12'h0c8, 0);
        `CHK(rd, 32'h06)
        for (int f = 0; f < 3; f++) begin
            apb(1, 12'h0c8, 32'(f));
            pin_b_pad_i <= 1'b1;
            repeat (6) @(posedge clk_i);
            `CHK({pin_b_pad_oe_n_o, pin_b_input_o}, {1'b1, f == 1})
            pin_b_pad_i <= 1'b0;
            repeat (6) @(posedge clk_i);
            `CHK(pin_b_input_o, f == 2)
        end
        $display("test pin done");
    endtask
    task automatic t_lead(input logic [7:0] v, input logic lvl, input int exp);
        int n = 0;
        apb(1, 12'h0c8, {24'h0, v}); // pin a stays out of the pulse modes
        repeat (3) @(posedge clk_i);
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        while (emit_pre_i !== 1'b1) @(posedge clk_i);
        // count cycles from the pre-emit edge to the pad turning active
        while (pin_b_pad_o !== lvl && n < 60) begin
            @(posedge clk_i);
            n++;
        end
        `CHK(n >= exp && n <= exp + 3, 1'b1)
        // the pad is back to inactive two cycles after the emitter sequence is over
        while (emit_pre_i === 1'b1) @(posedge clk_i);
        repeat (2) @(posedge clk_i);
        `CHK(pin_b_pad_o, !lvl)
        $display("test lead done");
    endtask
    task automatic t_power();
        logic [7:0] pv[4] = '{8'hec, 8'h40, 8'h80, 8'h28};
        logic [3:0] pe[4] = '{4'hf, 4'h0, 4'h8, 4'h3};
        idle_i <= 1'b1;
        wait_period_i <= 1'b1;
        retrim_req_i <= 1'b1;
        foreach (pv[i]) begin
            apb(1, 12'h0cc, {24'h0, pv[i]});
            repeat (3) @(posedge clk_i);
            `CHK(pwr, pe[i])
            apb(0, 12'h0cc, 0);
            `CHK(rd, {24'h0, pv[i]})
        end
        apb(1, 12'h0cc, 32'h00);
        idle_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        `CHK(pwr, 4'h2)
        $display("test power done");
    endtask
    task automatic t_int();
        int n = 0;
        for (int p = 0; p < 2; p++) begin
            apb(1, 12'h0cc, p ? 32'h04 : 32'h00);
            int_event_i <= 1'b1;
            @(posedge clk_i);
            int_event_i <= 1'b0;
            repeat (10) begin
                @(posedge clk_i);
                n += int_pin_o;
            end
        end
        `CHK(n, 14)
        // back to level mode: an event and a clear together leave the pin set
        apb(1, 12'h0cc, 32'h00);
        int_event_i <= 1'b1;
        int_clear_i <= 1'b1;
        @(posedge clk_i);
        int_event_i <= 1'b0;
        int_clear_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        `CHK(int_pin_o, 1'b1)
        int_clear_i <= 1'b1;
        @(posedge clk_i);
        int_clear_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        `CHK(int_pin_o, 1'b0)
        $display("test interrupt done");
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        t_reset();
        t_pin();
        t_lead(8'h04, 1'b1, 20);
        t_lead(8'h0c, 1'b1, 10);
        t_lead(8'h13, 1'b0, 0);
        t_lead(8'h1c, 1'b1, 20);
        t_power();
        t_int();
        conclude();
    end
endmodule
